// ---- conv_seq_control.sv ----
// Functional notes
// - Buffer mode set: alternate halves per interrupt.
// - Buffer mode clear: restart at start address.
// - Alternate sampling: toggle mux setting A/B.
// - Alternate sampling off: always setting A.
// - Read-only fill status shows second half.
// - DMA enabled: every result to first buffer.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_defs.svh"

module conv_seq_control
    import conv_ctrl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`ADDR_W-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic                  rc_clock,
    input  wire logic                  sample_start,
    output var  logic                  convert_start,
    output var  logic                  conversion_clock_source_rc,
    input  wire logic                  conv_done,
    input  wire logic [`RESULT_W-1:0]  conv_result,
    output var  logic                  conv_ready,
    output var  logic                  mux_select_b,
    output var  logic                  result_valid,
    input  wire logic                  result_ready,
    output var  logic [`PTR_W-1:0]     result_addr,
    output var  logic [`RESULT_W-1:0]  result_data,
    output var  logic                  conversion_interrupt,
    output var  logic                  dma_increment
);

    typedef struct packed {
        logic [4:0]           interrupt_rate_field;
        logic                 buffer_fill_mode_bit;
        logic                 alternate_sampling_bit;
        logic                 conversion_clock_source_bit;
        logic [4:0]           auto_sample_time_field;
        logic [7:0]           conversion_clock_divider_field;
        logic                 dma_result_enable_bit;
        logic                 fill_second;
        logic [`PTR_W-1:0]    buf_ptr;
        logic [4:0]           conv_count;
        logic                 mux_b;
        sample_state_t        sample_state;
        logic [4:0]           sample_count;
        logic [2:0]           rc_sync;
        logic                 rc_level;
        logic                 out_valid;
        logic [`PTR_W-1:0]    out_addr;
        logic [`RESULT_W-1:0] out_data;
        logic                 skid_valid;
        logic [`PTR_W-1:0]    skid_addr;
        logic [`RESULT_W-1:0] skid_data;
        logic                 conv_ready;
        logic                 irq;
        logic                 dma_inc;
        logic                 convert_start;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic        sys_tick;
    logic        rc_edge;
    logic        tad_tick;
    logic        push;
    logic        pop;
    logic        rate_hit;
    logic [`PTR_W-1:0] write_addr;
    logic        wr_access;

    tick_divider u_divider (
        .clk    (clk),
        .resetn (resetn),
        .divide (s.conversion_clock_divider_field),
        .tick   (sys_tick)
    );

    assign prdata                     = s.prdata;
    assign pready                     = s.pready;
    assign pslverr                    = s.pslverr;
    assign convert_start              = s.convert_start;
    assign conversion_clock_source_rc = s.conversion_clock_source_bit;
    assign conv_ready                 = s.conv_ready;
    assign mux_select_b               = s.mux_b;
    assign result_valid               = s.out_valid;
    assign result_addr                = s.out_addr;
    assign result_data                = s.out_data;
    assign conversion_interrupt       = s.irq;
    assign dma_increment              = s.dma_inc;

    // ------------------------------------------------------------------------
    // Conversion clock and data path events
    // ------------------------------------------------------------------------
    // The RC clock is asynchronous; an edge counts only once the two later
    // stages agree, so a metastable first stage never reaches the logic.
    assign rc_edge    = (s.rc_sync[1] == s.rc_sync[2]) && s.rc_sync[1] && !s.rc_level;
    assign tad_tick   = s.conversion_clock_source_bit ? rc_edge : sys_tick;
    assign push       = conv_done && s.conv_ready;
    assign pop        = s.out_valid && result_ready;
    assign rate_hit   = push && (s.conv_count == s.interrupt_rate_field);
    assign write_addr = s.dma_result_enable_bit ? `PTR_START : s.buf_ptr;
    assign wr_access  = psel && penable && s.pready && pwrite;

    always_comb begin
        next_s = s;
        next_s.irq           = 1'b0;
        next_s.dma_inc       = 1'b0;
        next_s.convert_start = 1'b0;

        // --------------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------------
        if (wr_access) begin
            case (paddr)
                `OFS_CONTROL_TWO: begin
                    next_s.interrupt_rate_field   = pwdata[`C2_SMPI_HI:`C2_SMPI_LO];
                    next_s.buffer_fill_mode_bit   = pwdata[`C2_BUFFER_FILL_MODE_BIT];
                    next_s.alternate_sampling_bit = pwdata[`C2_ALTERNATE_SAMPLING_BIT];
                end
                `OFS_TIMING: begin
                    next_s.conversion_clock_source_bit    = pwdata[`TM_CONVERSION_CLOCK_SOURCE_BIT];
                    next_s.auto_sample_time_field         = pwdata[`TM_SAMC_HI:`TM_SAMC_LO];
                    next_s.conversion_clock_divider_field = pwdata[`TM_ADCS_HI:`TM_ADCS_LO];
                end
                `OFS_DMA: begin
                    next_s.dma_result_enable_bit = pwdata[`DM_DMAEN];
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Register reads, captured in the setup cycle
        // --------------------------------------------------------------------
        next_s.pready  = psel && !penable;
        next_s.pslverr = 1'b0;
        next_s.prdata  = `RDATA_ZERO;
        if (psel && !penable) begin
            case (paddr)
                `OFS_CONTROL_TWO: begin
                    next_s.prdata[`C2_STATUS] = s.buffer_fill_mode_bit && s.fill_second;
                    next_s.prdata[`C2_SMPI_HI:`C2_SMPI_LO] = s.interrupt_rate_field;
                    next_s.prdata[`C2_BUFFER_FILL_MODE_BIT] = s.buffer_fill_mode_bit;
                    next_s.prdata[`C2_ALTERNATE_SAMPLING_BIT] = s.alternate_sampling_bit;
                end
                `OFS_TIMING: begin
                    next_s.prdata[`TM_CONVERSION_CLOCK_SOURCE_BIT] = s.conversion_clock_source_bit;
                    next_s.prdata[`TM_SAMC_HI:`TM_SAMC_LO] = s.auto_sample_time_field;
                    next_s.prdata[`TM_ADCS_HI:`TM_ADCS_LO] = s.conversion_clock_divider_field;
                end
                `OFS_DMA: begin
                    next_s.prdata[`DM_DMAEN] = s.dma_result_enable_bit;
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Auto-sample timing
        // --------------------------------------------------------------------
        next_s.rc_sync = {s.rc_sync[1:0], rc_clock};
        if (s.rc_sync[1] == s.rc_sync[2]) begin
            next_s.rc_level = s.rc_sync[2];
        end
        case (s.sample_state)
            SAMPLE_IDLE: begin
                if (sample_start) begin
                    if (s.auto_sample_time_field == `SAMC_RESET) begin
                        next_s.convert_start = 1'b1;
                    end else begin
                        next_s.sample_state = SAMPLE_RUN;
                        next_s.sample_count = s.auto_sample_time_field;
                    end
                end
            end
            SAMPLE_RUN: begin
                if (tad_tick) begin
                    next_s.sample_count = s.sample_count - `COUNT_STEP;
                    if (s.sample_count == `COUNT_STEP) begin
                        next_s.convert_start = 1'b1;
                        next_s.sample_state  = SAMPLE_IDLE;
                    end
                end
            end
            default: begin
                next_s.sample_state = SAMPLE_IDLE;
            end
        endcase

        // --------------------------------------------------------------------
        // Input selection, rate counting and buffer addressing
        // --------------------------------------------------------------------
        if (!s.alternate_sampling_bit) begin
            next_s.mux_b = 1'b0;
        end else if (push) begin
            next_s.mux_b = !s.mux_b;
        end
        if (push) begin
            if (rate_hit) begin
                next_s.conv_count = `SMPI_RESET;
                next_s.irq        = !s.dma_result_enable_bit;
                next_s.dma_inc    = s.dma_result_enable_bit;
                if (s.buffer_fill_mode_bit) begin
                    next_s.fill_second = !s.fill_second;
                    next_s.buf_ptr = s.fill_second ? `PTR_FIRST_HALF : `PTR_SECOND_HALF;
                end else begin
                    next_s.fill_second = 1'b0;
                    next_s.buf_ptr     = `PTR_START;
                end
            end else begin
                next_s.conv_count = s.conv_count + `COUNT_STEP;
                next_s.buf_ptr    = s.buf_ptr + `PTR_STEP;
            end
        end

        // --------------------------------------------------------------------
        // Two-entry result buffer
        // --------------------------------------------------------------------
        // A stalled reader parks one word in the skid entry; conv_ready then
        // drops, so the converter holds off instead of losing a result.
        if (!s.out_valid || pop) begin
            if (s.skid_valid) begin
                next_s.out_valid  = 1'b1;
                next_s.out_addr   = s.skid_addr;
                next_s.out_data   = s.skid_data;
                next_s.skid_valid = push;
                next_s.skid_addr  = write_addr;
                next_s.skid_data  = conv_result;
            end else begin
                next_s.out_valid  = push;
                next_s.out_addr   = write_addr;
                next_s.out_data   = conv_result;
            end
        end else if (push) begin
            next_s.skid_valid = 1'b1;
            next_s.skid_addr  = write_addr;
            next_s.skid_data  = conv_result;
        end
        next_s.conv_ready = !next_s.skid_valid;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.conv_ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_irq_on_rate: assert property (rate_hit && !s.dma_result_enable_bit |=> conversion_interrupt && !dma_increment)
        else $error("Interrupt missing after the programmed conversion count.");
    a_irq_not_early: assert property (push && !rate_hit |=> !conversion_interrupt)
        else $error("Interrupt raised before the programmed conversion count.");
    a_half_swap: assert property (rate_hit && s.buffer_fill_mode_bit
        |=> s.fill_second != $past(s.fill_second) && s.buf_ptr[3] == s.fill_second)
        else $error("Buffer half did not alternate at the interrupt.");
    a_ptr_restart: assert property (rate_hit && !s.buffer_fill_mode_bit |=> s.buf_ptr == `PTR_START)
        else $error("Buffer pointer did not return to the start address.");
    a_mux_toggle: assert property (push && s.alternate_sampling_bit |=> mux_select_b != $past(mux_select_b))
        else $error("Input selection did not alternate.");
    a_mux_fixed_a: assert property (!s.alternate_sampling_bit |=> !mux_select_b)
        else $error("Setting B used while alternate sampling is off.");
    a_status_read: assert property (psel && !penable && paddr == `OFS_CONTROL_TWO
        |=> prdata[`C2_STATUS] == $past(s.buffer_fill_mode_bit && s.fill_second))
        else $error("Fill status bit read back wrong.");
    a_dma_first_reg: assert property (push && s.dma_result_enable_bit && !s.out_valid
        |=> result_valid && result_addr == `PTR_START)
        else $error("Result not placed in the first buffer register under DMA.");
    a_sample_zero: assert property (s.sample_state == SAMPLE_IDLE && sample_start
        && s.auto_sample_time_field == `SAMC_RESET |=> convert_start)
        else $error("Zero auto-sample time did not start conversion at once.");

endmodule
`default_nettype wire

// ---- conv_ctrl_defs.svh ----
`ifndef CONV_CTRL_DEFS_SVH
`define CONV_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_W          12
`define OFS_CONTROL_TWO 12'h000
`define OFS_TIMING      12'h004
`define OFS_DMA         12'h008

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define C2_STATUS       7
`define C2_SMPI_HI      6
`define C2_SMPI_LO      2
`define C2_BUFFER_FILL_MODE_BIT         1
`define C2_ALTERNATE_SAMPLING_BIT         0
`define TM_CONVERSION_CLOCK_SOURCE_BIT         15
`define TM_SAMC_HI      12
`define TM_SAMC_LO      8
`define TM_ADCS_HI      7
`define TM_ADCS_LO      0
`define DM_DMAEN        8

// ----------------------------------------------------------------------------
// Widths, reset values and buffer layout
// ----------------------------------------------------------------------------
`define RESULT_W        12
`define PTR_W           4
`define SMPI_RESET      5'h00
`define SAMC_RESET      5'h00
`define ADCS_RESET      8'h00
`define PTR_FIRST_HALF  4'h0
`define PTR_SECOND_HALF 4'h8
`define PTR_START       4'h0
`define PTR_STEP        4'h1
`define COUNT_STEP      5'h01
`define DIV_STEP        8'h01
`define RDATA_ZERO      32'h0000_0000

`endif

// ---- conv_ctrl_pkg.sv ----
`default_nettype none
package conv_ctrl_pkg;

    typedef enum logic [0:0] {
        SAMPLE_IDLE = 1'b0,
        SAMPLE_RUN  = 1'b1
    } sample_state_t;

endpackage
`default_nettype wire

// ---- tick_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_defs.svh"

module tick_divider
    import conv_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] divide,
    output var  logic       tick
);

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } div_state_t;

    div_state_t s;
    div_state_t next_s;

    assign tick = s.tick;

    // ------------------------------------------------------------------------
    // One pulse every divide plus one cycles.
    // ------------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.count >= divide) begin
            next_s.count = 8'h00;
            next_s.tick  = 1'b1;
        end else begin
            next_s.count = s.count + `DIV_STEP;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_tick_spacing: assert property (tick && divide == 8'h01 && $stable(divide) |=> !tick ##1 tick)
        else $error("Conversion clock tick spacing wrong for divider one.");

endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_defs.svh"

module tb_top;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                 clk;
    logic                 resetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [`ADDR_W-1:0]   paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 rc_clock;
    logic                 sample_start;
    logic                 convert_start;
    logic                 conversion_clock_source_rc;
    logic                 conv_done;
    logic [`RESULT_W-1:0] conv_result;
    logic                 conv_ready;
    logic                 mux_select_b;
    logic                 result_valid;
    logic                 result_ready;
    logic [`PTR_W-1:0]    result_addr;
    logic [`RESULT_W-1:0] result_data;
    logic                 conversion_interrupt;
    logic                 dma_increment;
    int                   bad_count;
    int                   num_checks;
    int                   irq_count;
    int                   dma_count;
    logic [15:0]          got_q[$];

    conv_seq_control conv_seq_control_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_clock(rc_clock), .sample_start(sample_start),
        .convert_start(convert_start), .conversion_clock_source_rc(conversion_clock_source_rc),
        .conv_done(conv_done), .conv_result(conv_result), .conv_ready(conv_ready),
        .mux_select_b(mux_select_b), .result_valid(result_valid), .result_ready(result_ready),
        .result_addr(result_addr), .result_data(result_data),
        .conversion_interrupt(conversion_interrupt), .dma_increment(dma_increment));

    // ------------------------------------------------------------------
    // Clocks, monitor and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The RC pin runs free and unrelated to clk, so its synchroniser sees real edges.
    initial begin
        rc_clock = 1'b0;
        forever #10.3 rc_clock = ~rc_clock;
    end

    always @(posedge clk) begin
        if (resetn === 1'b1) begin
            if (result_valid === 1'b1 && result_ready === 1'b1) got_q.push_back({result_addr, result_data});
            if (conversion_interrupt === 1'b1) irq_count++;
            if (dma_increment === 1'b1) dma_count++;
        end
    end

    initial begin
        #200000;
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        stop_test();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        result_ready <= 1'b1;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        got_q.delete();
        irq_count = 0;
        dma_count = 0;
        @(posedge clk);
    endtask

    // Holds the request until pready is sampled high; one idle edge follows so calls may chain.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input logic err_exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(what, exp, r);
        check({what, " pslverr"}, {31'h0, err_exp}, {31'h0, e});
    endtask

    task automatic send(input logic [11:0] d);
        while (conv_ready !== 1'b1) begin
            @(posedge clk);
        end
        conv_done <= 1'b1;
        conv_result <= d;
        @(posedge clk);
        conv_done <= 1'b0;
        @(posedge clk);
    endtask

    task automatic sample_delay(output int n);
        sample_start <= 1'b1;
        @(posedge clk);
        sample_start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (convert_start !== 1'b1 && n < 200);
        @(posedge clk);
        check("convert_start single pulse", 32'h0, {31'h0, convert_start});
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        int n;
        logic [15:0] w;
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        sample_start = 1'b0; conv_done = 1'b0; conv_result = '0; result_ready = 1'b1;
        bad_count = 0; num_checks = 0; irq_count = 0; dma_count = 0;
        do_reset();
        reg_chk(`OFS_CONTROL_TWO, 32'h0, 1'b0, "control_two reset");
        reg_chk(`OFS_TIMING, 32'h0, 1'b0, "timing reset");
        reg_chk(`OFS_DMA, 32'h0, 1'b0, "dma reset");
        reg_wr(12'h00c, 32'hffff_ffff);
        reg_chk(12'h00c, 32'h0, 1'b1, "unmapped read");
        reg_chk(`OFS_CONTROL_TWO, 32'h0, 1'b0, "unmapped write ignored");
        reg_wr(`OFS_TIMING, 32'h0000_8305);
        reg_chk(`OFS_TIMING, 32'h0000_8305, 1'b0, "timing readback");
        check("clock source rc", 32'h1, {31'h0, conversion_clock_source_rc});
        // The RC pin is unrelated to clk, so its phase and the synchroniser add slack.
        reg_wr(`OFS_TIMING, 32'h0000_8300);
        sample_delay(n);
        check("sample time three rc ticks", 32'h1, {31'h0, n >= 11 && n <= 19});
        reg_wr(`OFS_TIMING, 32'h0000_0000);
        sample_delay(n);
        check("sample time zero", 32'h1, n);
        // Tick phase against sample_start is free, so allow one divider period of slack.
        reg_wr(`OFS_TIMING, 32'h0000_0301);
        sample_delay(n);
        check("sample time three ticks", 32'h1, {31'h0, n >= 5 && n <= 10});
        check("clock source system", 32'h0, {31'h0, conversion_clock_source_rc});

        // Every second result, restart at start address, alternate mux; status bit not writable.
        reg_wr(`OFS_CONTROL_TWO, 32'h0000_0085);
        reg_chk(`OFS_CONTROL_TWO, 32'h0000_0005, 1'b0, "status read only");
        for (int i = 0; i < 4; i++) begin
            send(12'h100 + i[11:0]);
            repeat (3) @(posedge clk);
            check("interrupt count", (i + 1) / 2, irq_count);
            check("mux select b", (i + 1) % 2, {31'h0, mux_select_b});
        end
        for (int i = 0; i < 4; i++) begin
            w = (got_q.size() > i) ? got_q[i] : 16'hxxxx;
            check("restart address word", {16'h0, i[0] ? 4'h1 : 4'h0, 12'h100 + i[11:0]}, {16'h0, w});
        end

        // Alternating halves with the fill status following the half in use.
        do_reset();
        reg_wr(`OFS_CONTROL_TWO, 32'h0000_0006);
        for (int i = 0; i < 6; i++) begin
            send(12'h200 + i[11:0]);
            repeat (3) @(posedge clk);
            check("mux stays a", 32'h0, {31'h0, mux_select_b});
            reg_chk(`OFS_CONTROL_TWO, {24'h0, (((i + 1) / 2) % 2 == 1), 7'h06}, 1'b0, "fill status");
        end
        for (int i = 0; i < 6; i++) begin
            w = (got_q.size() > i) ? got_q[i] : 16'hxxxx;
            check("half address", {28'h0, (i % 4 >= 2) ? 4'h8 : 4'h0} + (i % 2), {28'h0, w[15:12]});
        end

        // DMA mode: every result at the first location, increment pulse instead of interrupt.
        do_reset();
        reg_wr(`OFS_DMA, 32'h0000_0100);
        reg_chk(`OFS_DMA, 32'h0000_0100, 1'b0, "dma readback");
        reg_wr(`OFS_CONTROL_TWO, 32'h0000_0004);
        for (int i = 0; i < 4; i++) send(12'h300 + i[11:0]);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            w = (got_q.size() > i) ? got_q[i] : 16'hxxxx;
            check("dma address word", {16'h0, 4'h0, 12'h300 + i[11:0]}, {16'h0, w});
        end
        check("dma increments", 32'h2, dma_count);
        check("no interrupt in dma", 32'h0, irq_count);

        // Stalled reader: two words fill the buffer, then drain in order.
        do_reset();
        result_ready <= 1'b0;
        send(12'h4a5);
        send(12'h45a);
        repeat (2) @(posedge clk);
        check("buffer full refuses", 32'h0, {31'h0, conv_ready});
        check("word held", 32'h1, {31'h0, result_valid});
        result_ready <= 1'b1;
        repeat (4) @(posedge clk);
        check("drained words", 32'h2, got_q.size());
        if (got_q.size() == 2) begin
            check("first word", 32'h4a5, {20'h0, got_q[0][11:0]});
            check("second word", 32'h45a, {20'h0, got_q[1][11:0]});
        end
        check("buffer empty", 32'h0, {31'h0, result_valid});
        stop_test();
    end

endmodule

`default_nettype wire
